// ==== logic/tbd_time_base.sv ====
// Purpose: periodic tick and buzzer square wave from a shared divider
// Assumes: ref_clk_i is the high-frequency clock; low_freq_tick_i
//          is a one-cycle pulse per low-frequency clock period
// Notes: divider is never cleared by software
//
// What this block does
// - tick on each falling edge of tap
// - enabling tick leaves divider running
// - high clock tick taps per code
// - low clock tick taps; slow modes codes 0-1
// - buzzer pin active-low square wave when enabled
// - buzzer fields share control register
// - buzzer taps for high and low clocks
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module tbd_time_base
    import tbd_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic low_freq_tick_i,
    input wire logic [1:0] op_mode_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic tick_irq_o,
    output logic buzzer_out_n_o
);

    // =====================================================
    // declarations
    logic [7:0] ctrl_reg;
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [TBD_DIV_W-1:0] div_reg;
    logic tick_tap_d_reg;
    logic buz_tap_d_reg;
    logic [7:0] rdata_next;
    tbd_mode_t mode;
    logic slow_clk;
    logic use_fs;
    logic low_carry;
    logic hi_step;
    logic [2:0] tick_code;
    logic [1:0] buz_code;
    logic tick_tap;
    logic buz_tap;
    logic tick_avail;
    logic tick_fall;
    logic buz_rise;
    logic tick_pulse;

    // =====================================================
    // mode and source decode
    assign mode = tbd_mode_t'(op_mode_i);
    assign slow_clk = (mode == TBD_MODE_SLOW) || (mode == TBD_MODE_SLEEP);
    assign use_fs = ctrl_reg[TBD_B_SRC] || slow_clk;
    assign tick_code = ctrl_reg[TBD_F_TICK_LO +: 3];
    assign buz_code = ctrl_reg[TBD_F_BUZ_LO +: 2];
    assign low_carry = &div_reg[TBD_LOW_W-1:0];
    assign hi_step = use_fs ? low_freq_tick_i : low_carry;

    // =====================================================
    // shared divider: low stages on the high clock,
    // upper stages fed by carry or by the low clock
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            div_reg <= '0;
        end else if (ce_i) begin
            div_reg[TBD_LOW_W-1:0] <= div_reg[TBD_LOW_W-1:0] + 8'h01;
            if (hi_step) begin
                div_reg[TBD_DIV_W-1:TBD_LOW_W] <=
                    div_reg[TBD_DIV_W-1:TBD_LOW_W] + 15'h0001;
            end
        end
    end

    // =====================================================
    // tap selection
    assign tick_tap = div_reg[TBD_TICK_TAP[tick_code]];
    assign buz_tap = div_reg[TBD_BUZ_TAP[buz_code]];
    assign tick_avail = !slow_clk || (tick_code <= TBD_SLOW_MAX_CODE);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tick_tap_d_reg <= 1'b0;
            buz_tap_d_reg <= 1'b0;
        end else if (ce_i) begin
            tick_tap_d_reg <= tick_tap;
            buz_tap_d_reg <= buz_tap;
        end
    end

    // falling edge while enabled; the divider is left alone on enable
    assign tick_fall = tick_tap_d_reg && !tick_tap;
    assign tick_pulse = tick_fall && ctrl_reg[TBD_B_TICK_EN] && tick_avail;
    assign buz_rise = !buz_tap_d_reg && buz_tap && ctrl_reg[TBD_B_BUZ_EN];

    // =====================================================
    // tick request output
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tick_irq_o <= 1'b0;
        end else if (ce_i) begin
            tick_irq_o <= tick_pulse;
        end
    end

    // =====================================================
    // buzzer pin, idle high when disabled
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            buzzer_out_n_o <= 1'b1;
        end else if (ce_i) begin
            buzzer_out_n_o <= ctrl_reg[TBD_B_BUZ_EN] ? !buz_tap : 1'b1;
        end
    end

    // =====================================================
    // control register
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_reg <= TBD_CTRL_RST;
        end else if (ce_i && wr_i && addr_i == TBD_OFS_CTRL) begin
            ctrl_reg <= wdata_i;
        end
    end

    // =====================================================
    // mask register, next value shared with the interrupt level
    always_comb begin
        mask_next = mask_reg;
        if (wr_i && addr_i == TBD_OFS_MASK) begin
            mask_next = wdata_i & 8'h03;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            mask_reg <= TBD_MASK_RST;
        end else if (ce_i) begin
            mask_reg <= mask_next;
        end
    end

    // =====================================================
    // sticky status, write one to clear, set wins
    always_comb begin
        stat_next = stat_reg;
        if (wr_i && addr_i == TBD_OFS_STAT) begin
            stat_next = stat_reg & ~wdata_i;
        end
        if (tick_pulse) begin
            stat_next[TBD_B_ST_TICK] = 1'b1;
        end
        if (buz_rise) begin
            stat_next[TBD_B_ST_BUZ] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            stat_reg <= TBD_ZERO;
        end else if (ce_i) begin
            stat_reg <= stat_next;
        end
    end

    // =====================================================
    // interrupt level
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(stat_next & mask_next);
        end
    end

    // =====================================================
    // read port, data one cycle after the strobe
    always_comb begin
        rdata_next = TBD_ZERO;
        if (rd_i) begin
            unique case (addr_i)
                TBD_OFS_CTRL: rdata_next = ctrl_reg;
                TBD_OFS_STAT: rdata_next = stat_reg;
                TBD_OFS_MASK: rdata_next = mask_reg;
                TBD_OFS_DIVH: rdata_next = div_reg[TBD_DIV_W-1:TBD_DIVH_LO];
                TBD_OFS_MODE: rdata_next = {6'h00, op_mode_i};
                default: rdata_next = TBD_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_o <= TBD_ZERO;
        end else if (ce_i) begin
            rdata_o <= rdata_next;
        end
    end

    // =====================================================
    // checks
    property p_tick_on_fall;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && tick_fall && ctrl_reg[TBD_B_TICK_EN] && tick_avail |=> tick_irq_o;
    endproperty
    a_tick_on_fall: assert property (p_tick_on_fall)
        else $error("tick missed on tap falling edge");

    property p_tick_needs_cause;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && !(tick_fall && ctrl_reg[TBD_B_TICK_EN]) |=> !tick_irq_o;
    endproperty
    a_tick_needs_cause: assert property (p_tick_needs_cause)
        else $error("tick without enabled falling edge");

    property p_div_free_run;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && wr_i && addr_i == TBD_OFS_CTRL |=>
            div_reg[TBD_LOW_W-1:0] == $past(div_reg[TBD_LOW_W-1:0]) + 8'h01;
    endproperty
    a_div_free_run: assert property (p_div_free_run)
        else $error("divider disturbed by control write");

    property p_slow_codes;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && slow_clk && tick_code > TBD_SLOW_MAX_CODE |=> !tick_irq_o;
    endproperty
    a_slow_codes: assert property (p_slow_codes)
        else $error("tick on unavailable slow code");

    property p_buz_idle;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && !ctrl_reg[TBD_B_BUZ_EN] |=> buzzer_out_n_o;
    endproperty
    a_buz_idle: assert property (p_buz_idle)
        else $error("buzzer pin driven while disabled");

    property p_buz_follow;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && ctrl_reg[TBD_B_BUZ_EN] |=> buzzer_out_n_o == !$past(buz_tap);
    endproperty
    a_buz_follow: assert property (p_buz_follow)
        else $error("buzzer pin not following tap");

    property p_tick_one_cycle;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && tick_irq_o ##1 ce_i |-> !tick_irq_o;
    endproperty
    a_tick_one_cycle: assert property (p_tick_one_cycle)
        else $error("tick request longer than one cycle");

    property p_ctrl_write;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && wr_i && addr_i == TBD_OFS_CTRL |=>
            buz_code == $past(wdata_i[TBD_F_BUZ_LO +: 2]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("buzzer field not in control register");

    property p_irq_level;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i |=> irq_o == |(stat_reg & mask_reg);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level wrong");

    property p_stat_set_wins;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && tick_pulse |=> stat_reg[TBD_B_ST_TICK];
    endproperty
    a_stat_set_wins: assert property (p_stat_set_wins)
        else $error("tick status lost to a clear");

    property p_buz_status;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && buz_rise |=> stat_reg[TBD_B_ST_BUZ];
    endproperty
    a_buz_status: assert property (p_buz_status)
        else $error("buzzer status not set on rising tap");

    property p_rdata_idle;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && !rd_i |=> rdata_o == TBD_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not cleared after one cycle");

    property p_ctrl_readback;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && rd_i && addr_i == TBD_OFS_CTRL |=> rdata_o == $past(ctrl_reg);
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control readback wrong");

    property p_mode_readback;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && rd_i && addr_i == TBD_OFS_MODE |=> rdata_o == {6'h00, $past(op_mode_i)};
    endproperty
    a_mode_readback: assert property (p_mode_readback)
        else $error("mode readback wrong");

    property p_div_freeze;
        @(posedge ref_clk_i) disable iff (srst_i)
        !ce_i |=> div_reg == $past(div_reg);
    endproperty
    a_div_freeze: assert property (p_div_freeze)
        else $error("divider moved while frozen");

    property p_hi_carry;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && !use_fs && low_carry |=>
            div_reg[TBD_DIV_W-1:TBD_LOW_W] == $past(div_reg[TBD_DIV_W-1:TBD_LOW_W]) + 15'h0001;
    endproperty
    a_hi_carry: assert property (p_hi_carry)
        else $error("upper divider missed low carry");

    property p_lf_hold;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && use_fs && !low_freq_tick_i |=> $stable(div_reg[TBD_DIV_W-1:TBD_LOW_W]);
    endproperty
    a_lf_hold: assert property (p_lf_hold)
        else $error("upper divider stepped without low clock");

    property p_mask_write;
        @(posedge ref_clk_i) disable iff (srst_i)
        ce_i && wr_i && addr_i == TBD_OFS_MASK |=> mask_reg == ($past(wdata_i) & 8'h03);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write not taken");

    c_tick: cover property (@(posedge ref_clk_i) disable iff (srst_i) tick_irq_o);
    c_buz: cover property (@(posedge ref_clk_i) disable iff (srst_i)
        $fell(buzzer_out_n_o) ##[1:300] $rose(buzzer_out_n_o));
    c_irq: cover property (@(posedge ref_clk_i) disable iff (srst_i) $rose(irq_o));
    c_freeze: cover property (@(posedge ref_clk_i) disable iff (srst_i) !ce_i ##1 ce_i);
    c_slow_buz: cover property (@(posedge ref_clk_i) disable iff (srst_i) slow_clk && $fell(buzzer_out_n_o));

endmodule // tbd_time_base

// ==== logic/tbd_pkg.sv ====
// Purpose: constants for the time base and buzzer divider
// Assumes: 8-bit register port, one system clock
// Notes: offsets are byte addresses on the plain port
package tbd_pkg;
    // =====================================================
    // register map
    localparam logic [7:0] TBD_OFS_CTRL = 8'h00;
    localparam logic [7:0] TBD_OFS_STAT = 8'h04;
    localparam logic [7:0] TBD_OFS_MASK = 8'h08;
    localparam logic [7:0] TBD_OFS_DIVH = 8'h0c;
    localparam logic [7:0] TBD_OFS_MODE = 8'h10;
    localparam logic [7:0] TBD_CTRL_RST = 8'h00;
    localparam logic [7:0] TBD_MASK_RST = 8'h00;
    localparam logic [7:0] TBD_ZERO = 8'h00;

    // =====================================================
    // control and status field positions
    localparam int TBD_B_TICK_EN = 3;
    localparam int TBD_B_SRC = 4;
    localparam int TBD_B_BUZ_EN = 7;
    localparam int TBD_F_TICK_LO = 0;
    localparam int TBD_F_BUZ_LO = 5;
    localparam int TBD_B_ST_TICK = 0;
    localparam int TBD_B_ST_BUZ = 1;

    // =====================================================
    // divider shape
    localparam int TBD_DIV_W = 23;
    localparam int TBD_LOW_W = 8;
    localparam int TBD_HI_W = TBD_DIV_W - TBD_LOW_W;
    localparam int TBD_DIVH_LO = TBD_DIV_W - 8;

    // =====================================================
    // tap bit index per code; bit n toggles at clock/2^(n+1)
    localparam logic [4:0] TBD_TICK_TAP [8] = '{
        5'h16, 5'h14, 5'h0f, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h08};
    localparam logic [4:0] TBD_BUZ_TAP [4] = '{
        5'h0c, 5'h0b, 5'h0a, 5'h09};
    localparam logic [2:0] TBD_SLOW_MAX_CODE = 3'h1;

    // =====================================================
    // operating modes
    typedef enum logic [1:0] {
        TBD_MODE_NORMAL = 2'b00,
        TBD_MODE_IDLE = 2'b01,
        TBD_MODE_SLOW = 2'b10,
        TBD_MODE_SLEEP = 2'b11
    } tbd_mode_t;
endpackage

// ==== tb/tbd_buzzer_model.sv ====
// Purpose: piezo buzzer on the active-low divided-clock pin
// Assumes: pin sampled on the system clock
// Notes: reports period and low time of the last full cycle
`timescale 1ns/1ps
module tbd_buzzer_model (
    input wire logic ref_clk_i,
    input wire logic buzzer_out_n_i,
    output int period_o,
    output int low_o,
    output int edges_o
);
    // ====================
    // drive timing seen by the buzzer
    int t = 0;
    int t_fall = 0;
    logic last = 1'b1;
    always @(posedge ref_clk_i) begin
        t <= t + 1;
        last <= buzzer_out_n_i;
        if (last && !buzzer_out_n_i) begin
            period_o <= t - t_fall;
            t_fall <= t;
            edges_o <= edges_o + 1;
        end
        if (!last && buzzer_out_n_i) begin
            low_o <= t - t_fall;
        end
    end
endmodule // tbd_buzzer_model

// ==== tb/time_base_and_buzzer_divider_bench.sv ====
// Purpose: self-checking bench for the time base and buzzer divider
// Assumes: 200 MHz clock, low-frequency tick every 4 cycles
// Notes: rows cover rate codes; hand tests cover irq, refusal, freeze, reset
`timescale 1ns/1ps
module time_base_and_buzzer_divider_bench
    import tbd_pkg::*;
;
    typedef struct {
        logic [7:0] ctrl;
        logic [1:0] mode;
        int tp;
        int bp;
    } tbd_row_t;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic low_freq_tick_i = 1'b0;
    logic [1:0] op_mode_i = 2'h0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o;
    logic tick_irq_o;
    logic buzzer_out_n_o;
    logic [1:0] lf_cnt = 2'h0;
    int period;
    int low;
    int edges;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    // control, mode, tick period, buzzer period (cycles)
    tbd_row_t rows [11] = '{'{8'hef, 2'h0, 512, 1024}, '{8'hce, 2'h0, 2048, 2048},
        '{8'hff, 2'h0, 8, 16}, '{8'hde, 2'h1, 32, 32}, '{8'hbd, 2'h0, 64, 64},
        '{8'h9c, 2'h0, 128, 128}, '{8'h1b, 2'h0, 256, 0}, '{8'h1a, 2'h0, 1024, 0},
        '{8'h8f, 2'h1, 512, 8192}, '{8'he0, 2'h2, 0, 16}, '{8'hc0, 2'h3, 0, 32}};

    // ====================
    // design, buzzer, clocks
    tbd_time_base tbd_time_base_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .low_freq_tick_i(low_freq_tick_i), .op_mode_i(op_mode_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .tick_irq_o(tick_irq_o), .buzzer_out_n_o(buzzer_out_n_o));
    tbd_buzzer_model tbd_buzzer_model_i (.ref_clk_i(ref_clk_i), .buzzer_out_n_i(buzzer_out_n_o),
        .period_o(period), .low_o(low), .edges_o(edges));
    always #2.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        lf_cnt <= lf_cnt + 2'h1;
        low_freq_tick_i <= (lf_cnt == 2'h3);
    end
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            test_done();
        end
    end

    // ====================
    // tasks
    task test_done;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task tick_wait(output int n);
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (tick_irq_o !== 1'b1 && n < 40000);
    endtask

    // ====================
    // main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] prev;
        int n;
        int k;
        int e;
        prev = 8'h00;
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        foreach (rows[i]) begin
            wr(TBD_OFS_CTRL, prev & 8'h77);
            op_mode_i <= rows[i].mode;
            wr(TBD_OFS_CTRL, rows[i].ctrl & 8'h77);
            wr(TBD_OFS_CTRL, rows[i].ctrl);
            prev = rows[i].ctrl;
            rd(TBD_OFS_CTRL, d);
            check(d, prev);
            rd(TBD_OFS_MODE, d);
            check(d, {6'h00, rows[i].mode});
            if (rows[i].tp > 0) begin
                tick_wait(n);
                check(n <= rows[i].tp, 1'b1);
                tick_wait(n);
                check(n, rows[i].tp);
            end
            if (rows[i].bp > 0) begin
                e = edges;
                k = 0;
                while (edges < e + 2 && k < 30000) begin
                    @(posedge ref_clk_i);
                    #1;
                    k++;
                end
                check(period, rows[i].bp);
                check(low * 2, rows[i].bp);
            end
        end
        rd(8'h20, d);
        check(d, TBD_ZERO);
        rd(TBD_OFS_STAT, d);
        check(d[1:0], 2'b11);
        wr(8'h24, 8'h5a);
        rd(TBD_OFS_CTRL, d);
        check(d, prev);
        wr(TBD_OFS_CTRL, 8'h40);
        op_mode_i <= TBD_MODE_NORMAL;
        wr(TBD_OFS_MASK, 8'h01);
        wr(TBD_OFS_STAT, 8'h03);
        wr(TBD_OFS_CTRL, 8'h4f);
        tick_wait(n);
        check(irq_o, 1'b1);
        wr(TBD_OFS_CTRL, 8'h47);
        wr(TBD_OFS_STAT, 8'h01);
        #1;
        check(irq_o, 1'b0);
        rd(TBD_OFS_STAT, d);
        check(d[0], 1'b0);
        wr(TBD_OFS_MASK, 8'h00);
        wr(TBD_OFS_CTRL, 8'h4f);
        tick_wait(n);
        check(irq_o, 1'b0);
        rd(TBD_OFS_STAT, d);
        check(d[0], 1'b1);
        wr(TBD_OFS_CTRL, 8'h47);
        op_mode_i <= TBD_MODE_SLOW;
        wr(TBD_OFS_CTRL, 8'h4f);
        k = 0;
        repeat (1100) begin
            @(posedge ref_clk_i);
            #1;
            if (tick_irq_o === 1'b1) k++;
        end
        check(k, 0);
        check(buzzer_out_n_o, 1'b1);
        wr(TBD_OFS_CTRL, 8'h47);
        op_mode_i <= TBD_MODE_NORMAL;
        wr(TBD_OFS_CTRL, 8'h4f);
        tick_wait(n);
        repeat (10) @(posedge ref_clk_i);
        ce_i <= 1'b0;
        repeat (100) @(posedge ref_clk_i);
        ce_i <= 1'b1;
        tick_wait(n);
        check(n + 110, 612);
        @(posedge ref_clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rd(TBD_OFS_CTRL, d);
        check(d, TBD_CTRL_RST);
        rd(TBD_OFS_MASK, d);
        check(d, TBD_MASK_RST);
        rd(TBD_OFS_DIVH, d);
        check(d, TBD_ZERO);
        check({irq_o, buzzer_out_n_o}, 2'b01);
        test_done();
    end
endmodule // time_base_and_buzzer_divider_bench
